// file: pmbpc_control.sv
// Power control command interpreter: on/off, margining, write protection, fault counters.
// Function
// - Six fault counters, zero to 128, step one.
// - Out-of-range setting write sets comm error bit.
// - Top bits 00 stop the output.
// - Top bits 01 also stop the output.
// - Top 10, bits 5-4 00: nominal voltage on.
// - Margin low; bits 3-2 select low protection.
// - Margin high; bits 3-2 select overvoltage protection.
// - Ignored protection suppresses warning and fault both.
// - Config bit 4 is master on/off enable.
// - Config bit 3 enables control byte on/off.
// - Config bit 2 enables remote input on/off.
// - Config bit 1 selects remote input polarity.
// - Remote stop halts output two clocks after the pin changes.
// - Clear_all_faults clears status and releases alert.
// - Topmost protection allows only protection register writes.
// - Pattern 40 adds output control writes.
// - Pattern 20 adds config and voltage command.
// - Pattern 00 accepts every supported write.
`timescale 1ns/1ps
`include "pmbpc_defs.svh"
module pmbpc_control
  import pmbpc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             cmdWrite,
  input  wire logic             cmdSend,
  input  wire logic [7:0]       cmdCode,
  input  wire logic [7:0]       cmdData,
  input  wire logic [7:0]       rdCode,
  output logic      [7:0]       rdData,
  output logic                  rdValid,
  input  wire logic             remoteIn,
  input  wire logic [5:0]       faultEvent,
  input  wire logic             statusSet,
  output logic                  outputEnable,
  output pmbpc_margin_t         marginSelect,
  output logic                  ignoreLowProt,
  output logic                  ignoreOverProt,
  output logic                  alertActive,
  output logic                  clearPulse
);
  // Counter order: out OV, out UV, OT, UT, in OV, in UV.
  logic [7:0] outputControl_r;
  logic [7:0] onOffConfig_r;
  logic [7:0] writeProtection_r;
  logic [7:0] statusComm_r;
  logic       statusOther_r;
  logic [CNT_W-1:0] eventCount_r [`PMBPC_NUM_COUNTERS];
  logic remoteMeta_r;
  logic remoteSync_r;
  logic clearPulse_r;
  logic [7:0] rdData_r;
  logic       rdValid_r;

  function automatic logic wpAllows(input logic [7:0] wp, input logic [7:0] code);
    logic ok;
    ok = 1'b0;
    if (code == `PMBPC_OFF_WRITE_PROTECTION) begin
      ok = 1'b1;
    end else if (wp == `PMBPC_WP_CONTROL_ONLY) begin
      ok = (code == `PMBPC_OFF_OUTPUT_CONTROL);
    end else if (wp == `PMBPC_WP_CONTROL_CONFIG) begin
      ok = (code == `PMBPC_OFF_OUTPUT_CONTROL) || (code == `PMBPC_OFF_ON_OFF_CONFIG)
        || (code == `PMBPC_OFF_OUTPUT_VOLTAGE);
    end else if (wp == `PMBPC_WP_OPEN) begin
      ok = 1'b1;
    end
    return ok; // Topmost pattern falls through with only its own register open.
  endfunction

  function automatic logic wpValid(input logic [7:0] v);
    return (v == `PMBPC_WP_ALL_LOCKED) || (v == `PMBPC_WP_CONTROL_ONLY)
      || (v == `PMBPC_WP_CONTROL_CONFIG) || (v == `PMBPC_WP_OPEN);
  endfunction

  // Decoding of a write.
  wire writeAllowed = wpAllows(writeProtection_r, cmdCode);
  wire wrOutCtl     = cmdWrite && writeAllowed && (cmdCode == `PMBPC_OFF_OUTPUT_CONTROL);
  wire wrCfg        = cmdWrite && writeAllowed && (cmdCode == `PMBPC_OFF_ON_OFF_CONFIG);
  wire wrWp         = cmdWrite && (cmdCode == `PMBPC_OFF_WRITE_PROTECTION);
  wire [1:0] opTop  = cmdData[7:6];
  wire [1:0] opMar  = cmdData[5:4];
  wire [1:0] opPrt  = cmdData[3:2];
  // Only the combinations listed for the control byte, plus top bits 11, are in range.
  wire outCtlRange  = (opTop != 2'b10) || (opMar == 2'b00)
    || ((opMar != 2'b11) && ((opPrt == 2'b01) || (opPrt == 2'b10)));
  // Only the unused top bits are out of range; the read-only bit 0 is ignored on write.
  wire cfgRange     = (cmdData[7:5] == 3'b000);
  wire badOutCtl    = wrOutCtl && !outCtlRange;
  wire badCfg       = wrCfg && !cfgRange;
  wire badWp        = wrWp && !wpValid(cmdData);
  // A refused write is also a communication fault.
  wire deniedWrite  = cmdWrite && !writeAllowed;
  wire commError    = badOutCtl || badCfg || badWp || deniedWrite;
  wire clearCmd     = cmdSend && (cmdCode == `PMBPC_OFF_CLEAR_ALL_FAULTS);

  // On/off source selection.
  wire cfgMaster    = onOffConfig_r[`PMBPC_CFG_MASTER_BIT];
  wire cfgControl   = onOffConfig_r[`PMBPC_CFG_CONTROL_BIT];
  wire cfgRemote    = onOffConfig_r[`PMBPC_CFG_REMOTE_BIT];
  wire cfgPolarity  = onOffConfig_r[`PMBPC_CFG_POLARITY_BIT];
  wire remoteOn     = cfgPolarity ? remoteSync_r : !remoteSync_r;
  // Top bits 00 and 01 both mean off; no sequenced ramp-down exists.
  wire controlOn    = (outputControl_r[7:6] == 2'b10);
  wire controlOk    = !cfgControl || controlOn;
  wire remoteOk     = !cfgRemote || remoteOn;
  // With the master switch off, no source can stop or start the output.
  wire enableNext   = !cfgMaster || (controlOk && remoteOk);
  wire [1:0] marBits = outputControl_r[5:4];
  wire [1:0] prtBits = outputControl_r[3:2];

  assign outputEnable = enableNext;
  assign marginSelect = !controlOn ? PMBPC_MODE_NOMINAL
    : (marBits == 2'b01) ? PMBPC_MODE_LOW
    : (marBits == 2'b10) ? PMBPC_MODE_HIGH
    : PMBPC_MODE_NOMINAL;
  // Both warning and fault responses hang on these flags.
  assign ignoreLowProt  = controlOn && (marBits == 2'b01) && (prtBits == 2'b01);
  assign ignoreOverProt = controlOn && (marBits == 2'b10) && (prtBits == 2'b01);
  assign alertActive    = (statusComm_r != 8'h00) || statusOther_r;
  assign clearPulse     = clearPulse_r;
  assign rdData         = rdData_r;
  assign rdValid        = rdValid_r;

  // Remote pin crosses into the clock domain through two flops.
  always_ff @(posedge clk) begin
    if (rst) begin
      remoteMeta_r <= 1'b0;
      remoteSync_r <= 1'b0;
    end else begin
      remoteMeta_r <= remoteIn;
      remoteSync_r <= remoteMeta_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      outputControl_r <= `PMBPC_RST_OUTPUT_CONTROL;
    end else if (wrOutCtl && outCtlRange) begin
      outputControl_r <= cmdData & `PMBPC_OUTPUT_CONTROL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      onOffConfig_r <= `PMBPC_RST_ON_OFF_CONFIG;
    end else if (wrCfg && cfgRange) begin
      onOffConfig_r <= (cmdData & `PMBPC_ON_OFF_CONFIG_WMASK) | 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      writeProtection_r <= `PMBPC_RST_WRITE_PROTECTION;
    end else if (wrWp && !badWp) begin
      writeProtection_r <= cmdData;
    end
  end

  // A new error in the clearing cycle survives the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      statusComm_r  <= 8'h00;
      statusOther_r <= 1'b0;
      clearPulse_r  <= 1'b0;
    end else begin
      statusComm_r  <= (clearCmd ? 8'h00 : statusComm_r)
        | (commError ? (8'h01 << `PMBPC_COMM_INVALID_BIT) : 8'h00);
      statusOther_r <= (statusOther_r && !clearCmd) || statusSet || (|faultEvent);
      clearPulse_r  <= clearCmd;
    end
  end

  // Counters hold at the ceiling rather than wrap.
  genvar gi;
  generate
    for (gi = 0; gi < `PMBPC_NUM_COUNTERS; gi++) begin : gCount
      always_ff @(posedge clk) begin
        if (rst) begin
          eventCount_r[gi] <= '0;
        end else if (faultEvent[gi] && (eventCount_r[gi] < CNT_W'(`PMBPC_COUNT_MAX))) begin
          eventCount_r[gi] <= eventCount_r[gi] + CNT_W'(1);
        end
      end
    end
  endgenerate

  wire [7:0] rdMux =
    (rdCode == `PMBPC_OFF_OUTPUT_CONTROL)   ? outputControl_r :
    (rdCode == `PMBPC_OFF_ON_OFF_CONFIG)    ? onOffConfig_r :
    (rdCode == `PMBPC_OFF_WRITE_PROTECTION) ? writeProtection_r :
    (rdCode == `PMBPC_OFF_STATUS_COMM)      ? statusComm_r :
    (rdCode == `PMBPC_OFF_OUT_OV_COUNT)     ? 8'(eventCount_r[0]) :
    (rdCode == `PMBPC_OFF_OUT_UV_COUNT)     ? 8'(eventCount_r[1]) :
    (rdCode == `PMBPC_OFF_OT_COUNT)         ? 8'(eventCount_r[2]) :
    (rdCode == `PMBPC_OFF_UT_COUNT)         ? 8'(eventCount_r[3]) :
    (rdCode == `PMBPC_OFF_IN_OV_COUNT)      ? 8'(eventCount_r[4]) :
    (rdCode == `PMBPC_OFF_IN_UV_COUNT)      ? 8'(eventCount_r[5]) : 8'h00;
  wire rdHit = (rdCode == `PMBPC_OFF_OUTPUT_CONTROL) || (rdCode == `PMBPC_OFF_ON_OFF_CONFIG)
    || (rdCode == `PMBPC_OFF_WRITE_PROTECTION) || (rdCode == `PMBPC_OFF_STATUS_COMM)
    || (rdCode[7:4] == 4'hf && (rdCode[3:0] < 4'h4 || rdCode[3:0] == 4'h8
    || rdCode[3:0] == 4'h9));

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_r  <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdData_r  <= rdMux;
      rdValid_r <= rdHit;
    end
  end
endmodule

// file: pmbpc_control_props.sv
// Port checks for the power control command block.
`timescale 1ns/1ps
module pmbpc_control_props
  import pmbpc_pkg::*;
#(parameter int CNT_W = 8) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          cmdWrite,
  input wire logic          cmdSend,
  input wire logic [7:0]    cmdCode,
  input wire logic [7:0]    cmdData,
  input wire logic [7:0]    rdCode,
  input wire logic [7:0]    rdData,
  input wire logic          rdValid,
  input wire logic          remoteIn,
  input wire logic [5:0]    faultEvent,
  input wire logic          statusSet,
  input wire logic          outputEnable,
  input wire pmbpc_margin_t marginSelect,
  input wire logic          ignoreLowProt,
  input wire logic          ignoreOverProt,
  input wire logic          alertActive,
  input wire logic          clearPulse
);
  wire clr = cmdSend && cmdCode == 8'h03;
  wire bad = cmdWrite && cmdCode == 8'h01 && cmdData == 8'hb0;
  wire cnt = rdCode inside {8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf8, 8'hf9};
  wire quiet = !cmdWrite && !statusSet && faultEvent == 6'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  clr_pulse_a: assert property (clr |=> clearPulse) else $error("no clear pulse");
  clr_only_a: assert property (!clr |=> !clearPulse) else $error("stray pulse");
  alert_release_a: assert property (clr && quiet |=> !alertActive)
    else $error("alert kept");
  err_alert_a: assert property (bad |=> alertActive) else $error("no alert");
  err_flag_a: assert property (bad ##1 !clr ##1 (rdCode == 8'h7e && !clr) |=> rdData[7])
    else $error("comm bit clear");
  low_ignore_a: assert property (ignoreLowProt |-> marginSelect == PMBPC_MODE_LOW)
    else $error("low ignore");
  over_ignore_a: assert property (ignoreOverProt |-> marginSelect == PMBPC_MODE_HIGH)
    else $error("over ignore");
  count_max_a: assert property (cnt |=> rdValid && rdData <= 8'h80)
    else $error("count range");
  cover property (clr);
  cover property (bad);
  cover property (ignoreLowProt);
endmodule
bind pmbpc_control pmbpc_control_props #(.CNT_W(CNT_W)) props (.clk(clk), .rst(rst),
  .cmdWrite(cmdWrite), .cmdSend(cmdSend), .cmdCode(cmdCode), .cmdData(cmdData),
  .rdCode(rdCode), .rdData(rdData), .rdValid(rdValid), .remoteIn(remoteIn),
  .faultEvent(faultEvent), .statusSet(statusSet), .outputEnable(outputEnable),
  .marginSelect(marginSelect), .ignoreLowProt(ignoreLowProt),
  .ignoreOverProt(ignoreOverProt), .alertActive(alertActive), .clearPulse(clearPulse));

// file: pmbpc_defs.svh
// Offsets, field positions, reset values and fixed figures of the power control command block.
`ifndef PMBPC_DEFS_SVH
`define PMBPC_DEFS_SVH
`define PMBPC_OFF_OUTPUT_CONTROL   8'h01
`define PMBPC_OFF_ON_OFF_CONFIG    8'h02
`define PMBPC_OFF_CLEAR_ALL_FAULTS     8'h03
`define PMBPC_OFF_WRITE_PROTECTION 8'h10
`define PMBPC_OFF_OUTPUT_VOLTAGE   8'h21
`define PMBPC_OFF_STATUS_COMM      8'h7e
`define PMBPC_OFF_OUT_OV_COUNT     8'hf0
`define PMBPC_OFF_OUT_UV_COUNT     8'hf1
`define PMBPC_OFF_OT_COUNT         8'hf2
`define PMBPC_OFF_UT_COUNT         8'hf3
`define PMBPC_OFF_IN_OV_COUNT      8'hf8
`define PMBPC_OFF_IN_UV_COUNT      8'hf9
`define PMBPC_RST_OUTPUT_CONTROL   8'h00
`define PMBPC_RST_ON_OFF_CONFIG    8'h15
`define PMBPC_RST_WRITE_PROTECTION 8'h00
`define PMBPC_OUTPUT_CONTROL_WMASK 8'hbc
`define PMBPC_ON_OFF_CONFIG_WMASK  8'h1e
`define PMBPC_WP_ALL_LOCKED        8'h80
`define PMBPC_WP_CONTROL_ONLY      8'h40
`define PMBPC_WP_CONTROL_CONFIG    8'h20
`define PMBPC_WP_OPEN              8'h00
`define PMBPC_CFG_MASTER_BIT       4
`define PMBPC_CFG_CONTROL_BIT      3
`define PMBPC_CFG_REMOTE_BIT       2
`define PMBPC_CFG_POLARITY_BIT     1
`define PMBPC_COMM_INVALID_BIT     7
`define PMBPC_COUNT_MAX            8'h80
`define PMBPC_NUM_COUNTERS         6
`endif

// file: pmbpc_host.sv
// Host controller model issuing byte writes and send-byte commands.
`timescale 1ns/1ps
module pmbpc_host (
  input  wire logic       clk,
  output logic            cmdWrite = 1'b0,
  output logic            cmdSend = 1'b0,
  output logic [7:0]      cmdCode = 8'h00,
  output logic [7:0]      cmdData = 8'h00
);
  // Code and data turn to inverted junk outside a strobe, so nothing stale looks valid.
  task automatic xfer(input logic s, input logic [7:0] c, input logic [7:0] d);
    @(posedge clk);
    cmdWrite <= !s;
    cmdSend <= s;
    cmdCode <= c;
    cmdData <= d;
    @(posedge clk);
    cmdWrite <= 1'b0;
    cmdSend <= 1'b0;
    cmdCode <= ~c;
    cmdData <= ~d;
  endtask
endmodule

// file: pmbpc_pkg.sv
// Types shared by the power control command block.
package pmbpc_pkg;
  typedef enum logic [1:0] {
    PMBPC_MODE_NOMINAL = 2'b00,
    PMBPC_MODE_LOW     = 2'b01,
    PMBPC_MODE_HIGH    = 2'b10
  } pmbpc_margin_t;
endpackage

// file: test_pmbpc_control.sv
// Self-checking bench for the power control command block.
`timescale 1ns/1ps
module test_pmbpc_control;
  logic clk, rst, cmdWrite, cmdSend, rdValid, remoteIn, statusSet;
  logic outputEnable, ignoreLowProt, ignoreOverProt, alertActive, clearPulse;
  logic [7:0] cmdCode, cmdData, rdCode, rdData;
  logic [5:0] faultEvent;
  pmbpc_pkg::pmbpc_margin_t marginSelect;
  int fail_count = 0;
  int total_checks = 0;
  logic [15:0] rv [10] = '{16'h0100, 16'h0215, 16'h1000, 16'h7e00, 16'hf000,
                           16'hf100, 16'hf200, 16'hf300, 16'hf800, 16'hf900};
  logic [15:0] op [7] = '{16'h0000, 16'h4000, 16'h8010, 16'h9419, 16'h9811, 16'ha416, 16'ha812};
  logic [9:0] rm [6] = '{10'h058, 10'h05b, 10'h07a, 10'h052, 10'h051, 10'h013};
  logic [31:0] wp [4] = '{32'h80018000, 32'h40018080, 32'h40021e05, 32'h20021e1f};
  logic [7:0] ca [6] = '{8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf8, 8'hf9};
  pmbpc_host h (.clk(clk), .cmdWrite(cmdWrite), .cmdSend(cmdSend), .cmdCode(cmdCode),
    .cmdData(cmdData));
  pmbpc_control dut (.clk(clk), .rst(rst), .cmdWrite(cmdWrite), .cmdSend(cmdSend),
    .cmdCode(cmdCode), .cmdData(cmdData), .rdCode(rdCode), .rdData(rdData),
    .rdValid(rdValid), .remoteIn(remoteIn), .faultEvent(faultEvent), .statusSet(statusSet),
    .outputEnable(outputEnable), .marginSelect(marginSelect), .ignoreLowProt(ignoreLowProt),
    .ignoreOverProt(ignoreOverProt), .alertActive(alertActive), .clearPulse(clearPulse));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) rdCode <= a;
    @(posedge clk);
    #1 chk(rdData, e);
  endtask
  task automatic outs(input logic [7:0] e);
    #1 chk({3'h0, outputEnable, ignoreLowProt, ignoreOverProt, marginSelect}, e);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #500000;
    fail_count++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    rdCode = 8'h00;
    remoteIn = 1'b0;
    faultEvent = 6'h00;
    statusSet = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rv[i]) rdc(rv[i][15:8], rv[i][7:0]);
    outs(8'h10);
    $display("reset test done");
    h.xfer(1'b0, 8'h02, 8'h18);
    rdc(8'h02, 8'h19);
    foreach (op[i]) begin
      h.xfer(1'b0, 8'h01, op[i][15:8]);
      outs(op[i][7:0]);
    end
    $display("mode test done");
    h.xfer(1'b0, 8'h01, 8'hb0);
    rdc(8'h7e, 8'h80);
    rdc(8'h01, 8'ha8);
    @(posedge clk) statusSet <= 1'b1;
    @(posedge clk) statusSet <= 1'b0;
    h.xfer(1'b1, 8'h03, 8'h00);
    #1 chk({7'h0, clearPulse}, 8'h01);
    rdc(8'h7e, 8'h00);
    chk({7'h0, alertActive}, 8'h00);
    $display("clear test done");
    h.xfer(1'b0, 8'h01, 8'h00);
    foreach (rm[i]) begin
      h.xfer(1'b0, 8'h02, rm[i][9:2]);
      @(posedge clk) remoteIn <= rm[i][1];
      repeat (4) @(posedge clk);
      #1 chk({7'h0, outputEnable}, {7'h0, rm[i][0]});
    end
    $display("remote test done");
    h.xfer(1'b0, 8'h10, 8'h11);
    rdc(8'h10, 8'h00);
    rdc(8'h7e, 8'h80);
    h.xfer(1'b1, 8'h03, 8'h00);
    foreach (wp[i]) begin
      h.xfer(1'b0, 8'h10, wp[i][31:24]);
      h.xfer(1'b0, wp[i][23:16], wp[i][15:8]);
      rdc(wp[i][23:16], wp[i][7:0]);
    end
    h.xfer(1'b0, 8'h10, 8'h00);
    h.xfer(1'b0, 8'h01, 8'h80);
    rdc(8'h01, 8'h80);
    $display("protection test done");
    for (int i = 0; i < 6; i++)
      repeat (i == 0 ? 130 : i + 1) begin
        @(posedge clk) faultEvent <= 6'h01 << i;
        @(posedge clk) faultEvent <= 6'h00;
      end
    h.xfer(1'b1, 8'h03, 8'h00);
    foreach (ca[i]) rdc(ca[i], i == 0 ? 8'h80 : 8'(i + 1));
    $display("counter test done");
    @(posedge clk) rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(8'hf0, 8'h00);
    rdc(8'h02, 8'h15);
    rdc(8'h10, 8'h00);
    $display("second reset test done");
    close_out();
  end
endmodule
